//--- verilog/spf_sequencer.sv
// Stop mode power-fail sequencer top level
`timescale 1ns/100ps
`default_nettype none
module spf_sequencer
    import spf_pkg::*;
#(
    parameter int WARMUP_CYCLES = SPF_WARMUP_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic stopReq,
    input wire logic wakeIrq,
    input wire logic pfPriorityHigher,
    input wire logic pfFlagClear,
    input wire logic cfgWrite,
    input wire logic cfgStopMonitorOff,
    input wire logic [1:0] intervalSel,
    input wire logic aboveWarnPin,
    input wire logic aboveResetPin,
    input wire logic abovePowerOnPin,
    input wire logic ringClkPin,
    input wire logic portFourWrite,
    input wire logic portFourRead,
    input wire logic [7:0] portFourWriteData,
    output logic monitorEn,
    output logic regulatorEn,
    output logic xtalEn,
    output logic sramRetain,
    output logic cpuClkEn,
    output logic cpuRst,
    output logic powerFailWarningFlag,
    output logic stopMonitorOff,
    output logic vectorValid,
    output logic vectorSel,
    output logic [7:0] portFourReadData
);
    // Analog and ring inputs: stage one and two of the synchronisers
    logic [3:0] syncA_ff;
    logic [3:0] syncB_ff;
    logic ringPrev_ff; // Last synchronised ring level
    logic aboveWarn;
    logic aboveReset;
    logic abovePowerOn;
    logic ringTick; // One cycle per ring-oscillator rising edge
    logic xtalReady;

    spf_state_type state_ff;
    spf_state_type nxt_state;
    logic [13:0] ticks_ff; // Ring ticks in the current wait or window
    logic [13:0] nxt_ticks;
    logic [1:0] settle_ff; // Wake check settle cycles
    logic [1:0] nxt_settle;
    logic resume_ff; // Warm-up ends by resuming, not by reboot
    logic nxt_resume;
    logic okWindow_ff; // Supply stayed above reset in window
    logic nxt_okWindow;
    // Output registers
    logic monitorEn_ff, regulatorEn_ff, xtalEn_ff, sramRetain_ff;
    logic cpuClkEn_ff, cpuRst_ff, flag_ff, monOff_ff, vecValid_ff, vecSel_ff;
    logic nxt_monitorEn, nxt_regulatorEn, nxt_xtalEn, nxt_sramRetain;
    logic nxt_cpuClkEn, nxt_cpuRst, nxt_flag, nxt_monOff, nxt_vecValid, nxt_vecSel;
    logic [7:0] portFourRead_ff;
    logic flagSet;

    assign aboveWarn = syncB_ff[0];
    assign aboveReset = syncB_ff[1];
    assign abovePowerOn = syncB_ff[2];
    assign ringTick = syncB_ff[3] & ~ringPrev_ff;

    // Interval length for a select code
    function automatic logic [13:0] spf_interval(input logic [1:0] sel);
        case (sel)
            SPF_IVL_2P11: spf_interval = SPF_TICKS_2P11;
            SPF_IVL_2P12: spf_interval = SPF_TICKS_2P12;
            SPF_IVL_2P13: spf_interval = SPF_TICKS_2P13;
            default: spf_interval = 14'h0000;
        endcase
    endfunction : spf_interval

    // Crystal warm-up counter
    spf_warmup_timer #(
        .WARMUP_CYCLES(WARMUP_CYCLES)
    ) warmup_inst (
        .clk_sys(clk_sys),
        .rst(rst),
        .xtalOn(xtalEn_ff),
        .xtalReady(xtalReady)
    );

    // Synchronise comparators and ring clock
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            syncA_ff <= 4'h0;
            syncB_ff <= 4'h0;
            ringPrev_ff <= 1'b0;
        end
        else
        begin
            syncA_ff <= {ringClkPin, abovePowerOnPin, aboveResetPin, aboveWarnPin};
            syncB_ff <= syncA_ff;
            ringPrev_ff <= syncB_ff[3];
        end
    end

    // Sequencer next state
    always_comb
    begin
        nxt_state = state_ff;
        nxt_ticks = ticks_ff;
        nxt_settle = settle_ff;
        nxt_resume = resume_ff;
        nxt_okWindow = okWindow_ff;
        nxt_vecValid = 1'b0;
        nxt_vecSel = vecSel_ff;
        flagSet = 1'b0;
        case (state_ff)
            SPF_RUN:
            begin
                // Monitor runs continuously while executing
                if (!aboveReset)
                begin
                    nxt_state = SPF_PF_WAIT;
                    nxt_ticks = 14'h0000;
                end
                else
                begin
                    flagSet = !aboveWarn;
                    if (stopReq)
                        nxt_state = SPF_STOP;
                end
            end
            SPF_STOP:
            begin
                if (wakeIrq)
                begin
                    nxt_state = SPF_WAKE_CHECK; // RULE_03
                    nxt_settle = 2'h0;
                end
                else if (!monOff_ff && !aboveReset)
                begin
                    // Monitor left on in stop sees the reset band
                    nxt_state = SPF_PF_WAIT;
                    nxt_ticks = 14'h0000;
                end
                else if (!monOff_ff && !aboveWarn)
                begin
                    // Monitor left on in stop wakes on the warning
                    flagSet = 1'b1;
                    nxt_resume = 1'b1;
                    nxt_state = SPF_WARMUP;
                end
                // With the monitor off the comparators are ignored: RULE_02
            end
            SPF_WAKE_CHECK:
            begin
                // Let the freshly enabled monitor settle through sync
                if (settle_ff != SPF_SETTLE_CYCLES)
                    nxt_settle = settle_ff + 2'h1;
                else if (!aboveReset)
                begin
                    nxt_state = SPF_PF_WAIT; // RULE_06
                    nxt_ticks = 14'h0000;
                end
                else
                begin
                    flagSet = !aboveWarn; // RULE_03
                    nxt_resume = 1'b1;
                    nxt_state = SPF_WARMUP; // RULE_04
                end
            end
            SPF_WARMUP:
            begin
                if (xtalReady)
                begin
                    // Resume into the vector, or boot out of reset: RULE_12
                    nxt_state = resume_ff ? SPF_VECTOR : SPF_RUN;
                    nxt_resume = 1'b0;
                end
            end
            SPF_VECTOR:
            begin
                // Pick the higher priority pending source
                nxt_vecValid = 1'b1;
                nxt_vecSel = (flag_ff && pfPriorityHigher) ? SPF_VEC_PFAIL : SPF_VEC_WAKE; // RULE_05
                nxt_state = SPF_RUN;
            end
            SPF_PF_WAIT:
            begin
                // Idle between probes for the chosen interval
                if (ticks_ff >= spf_interval(intervalSel)) // RULE_11
                begin
                    nxt_state = SPF_PROBE;
                    nxt_settle = 2'h0;
                    nxt_ticks = 14'h0000;
                    nxt_okWindow = 1'b1;
                end
                else if (ringTick)
                    nxt_ticks = ticks_ff + 14'h0001;
            end
            SPF_PROBE:
            begin
                // Detection on for two ring cycles, once settled
                if (settle_ff != SPF_SETTLE_CYCLES)
                    nxt_settle = settle_ff + 2'h1;
                else
                    nxt_okWindow = okWindow_ff & aboveReset;
                if (ringTick)
                begin
                    nxt_ticks = ticks_ff + 14'h0001;
                    if (ticks_ff[1:0] + 2'h1 == SPF_PROBE_TICKS) // RULE_10
                    begin
                        nxt_ticks = 14'h0000;
                        nxt_state = (okWindow_ff && aboveReset) ? SPF_CONFIRM : SPF_PF_WAIT;
                        nxt_okWindow = 1'b1;
                    end
                end
            end
            SPF_CONFIRM:
            begin
                // One further ring cycle above reset releases after warm-up
                nxt_okWindow = okWindow_ff & aboveReset;
                if (!aboveReset)
                begin
                    nxt_state = SPF_PF_WAIT; // RULE_10
                    nxt_ticks = 14'h0000;
                end
                else if (ringTick && ticks_ff[1:0] + 2'h1 == SPF_CONFIRM_TICKS)
                begin
                    nxt_state = SPF_WARMUP; // RULE_10
                    nxt_resume = 1'b0;
                    nxt_ticks = 14'h0000;
                end
                else if (ringTick)
                    nxt_ticks = ticks_ff + 14'h0001;
            end
            SPF_POR_HOLD:
            begin
                // Leave through the periodic probe once above power-on
                if (abovePowerOn)
                begin
                    nxt_state = SPF_PF_WAIT;
                    nxt_ticks = 14'h0000;
                end
            end
            default:
            begin
                nxt_state = SPF_POR_HOLD;
            end
        endcase
        // Power-on detector overrides the next state and any flag set
        if (!abovePowerOn)
        begin
            nxt_state = SPF_POR_HOLD; // RULE_07
            flagSet = 1'b0;
        end
        // Flag: a set in the clearing cycle wins
        nxt_flag = flagSet | (flag_ff & ~pfFlagClear);
        // Stop monitor off bit written by software
        nxt_monOff = cfgWrite ? cfgStopMonitorOff : monOff_ff;
    end

    // Supply and clock enables from the next state
    always_comb
    begin
        nxt_monitorEn = 1'b0;
        nxt_regulatorEn = 1'b0;
        nxt_xtalEn = 1'b0;
        nxt_sramRetain = 1'b1;
        nxt_cpuClkEn = 1'b0;
        nxt_cpuRst = 1'b1;
        case (nxt_state)
            SPF_RUN, SPF_VECTOR:
            begin
                nxt_monitorEn = 1'b1;
                nxt_regulatorEn = 1'b1;
                nxt_xtalEn = 1'b1;
                nxt_cpuClkEn = 1'b1; // RULE_12
                nxt_cpuRst = 1'b0;
            end
            SPF_STOP:
            begin
                nxt_monitorEn = !nxt_monOff; // RULE_01
                nxt_cpuRst = 1'b0;
            end
            SPF_WAKE_CHECK:
            begin
                nxt_monitorEn = 1'b1; // RULE_03
                nxt_cpuRst = 1'b0;
            end
            SPF_WARMUP:
            begin
                nxt_monitorEn = 1'b1;
                nxt_regulatorEn = 1'b1; // RULE_04
                nxt_xtalEn = 1'b1;
                nxt_cpuRst = !nxt_resume;
            end
            SPF_PF_WAIT:
            begin
                nxt_monitorEn = (intervalSel == SPF_IVL_CONT); // RULE_06
            end
            SPF_PROBE, SPF_CONFIRM:
            begin
                nxt_monitorEn = 1'b1; // RULE_10
            end
            default:
            begin
                nxt_sramRetain = 1'b0; // RULE_07
            end
        endcase
    end

    // Register sequencer state and outputs
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_ff <= SPF_POR_HOLD;
            ticks_ff <= 14'h0000;
            settle_ff <= 2'h0;
            resume_ff <= 1'b0;
            okWindow_ff <= 1'b0;
            monitorEn_ff <= 1'b0;
            regulatorEn_ff <= 1'b0;
            xtalEn_ff <= 1'b0;
            sramRetain_ff <= 1'b0;
            cpuClkEn_ff <= 1'b0;
            cpuRst_ff <= 1'b1;
            flag_ff <= 1'b0;
            monOff_ff <= SPF_MONITOR_OFF_RST; // RULE_09
            vecValid_ff <= 1'b0;
            vecSel_ff <= SPF_VEC_WAKE;
            portFourRead_ff <= SPF_PORT_FOUR_READ_RST;
        end
        else
        begin
            state_ff <= nxt_state;
            ticks_ff <= nxt_ticks;
            settle_ff <= nxt_settle;
            resume_ff <= nxt_resume;
            okWindow_ff <= nxt_okWindow;
            monitorEn_ff <= nxt_monitorEn;
            regulatorEn_ff <= nxt_regulatorEn;
            xtalEn_ff <= nxt_xtalEn;
            sramRetain_ff <= nxt_sramRetain;
            cpuClkEn_ff <= nxt_cpuClkEn;
            cpuRst_ff <= nxt_cpuRst;
            flag_ff <= nxt_flag;
            monOff_ff <= nxt_monOff;
            vecValid_ff <= nxt_vecValid;
            vecSel_ff <= nxt_vecSel;
            // Fourth port is absent: writes dropped, reads give zero
            portFourRead_ff <= SPF_PORT_FOUR_READ_RST; // RULE_08
        end
    end

    assign monitorEn = monitorEn_ff;
    assign regulatorEn = regulatorEn_ff;
    assign xtalEn = xtalEn_ff;
    assign sramRetain = sramRetain_ff;
    assign cpuClkEn = cpuClkEn_ff;
    assign cpuRst = cpuRst_ff;
    assign powerFailWarningFlag = flag_ff;
    assign stopMonitorOff = monOff_ff;
    assign vectorValid = vecValid_ff;
    assign vectorSel = vecSel_ff;
    assign portFourReadData = portFourRead_ff;

    // Port four strobes are accepted and have no effect
    logic unusedPortFour;
    assign unusedPortFour = ^{portFourWrite, portFourRead, portFourWriteData};
endmodule : spf_sequencer
`default_nettype wire

//--- verilog/spf_pkg.sv
// Constants, states and timing for the stop mode power-fail sequencer
// Contract
// (RULE_01) Stop with monitor off: all supplies off, retain
// (RULE_02) Monitor off in stop: no warning, no reset
// (RULE_03) On wake enable monitor, flag warning band
// (RULE_04) On wake restart regulator, crystal, await warm-up
// (RULE_05) Vector to higher priority of warning, wake
// (RULE_06) Wake in reset band: reset, periodic monitoring
// (RULE_07) Below power-on threshold: hold reset, all off
// (RULE_08) Fourth port registers absent, accesses do nothing
// (RULE_09) Stop monitor off bit resets to one
// (RULE_10) Probe two ring cycles, confirm one more
// (RULE_11) Interval: continuous, 2^11, 2^12, 2^13 ring clocks
// (RULE_12) CPU clock gated until crystal ready
package spf_pkg;
    // System clock period in ns
    localparam int SPF_CLK_PERIOD_NS = 10;
    // Crystal warm-up time in ns
    localparam int SPF_CRYSTAL_WARMUP_TIME_NS = 10000;
    // Warm-up cycles, rounded up
    localparam int SPF_WARMUP_CYCLES =
        (SPF_CRYSTAL_WARMUP_TIME_NS + SPF_CLK_PERIOD_NS - 1) / SPF_CLK_PERIOD_NS;
    // Cycles the wake check waits for synchronised comparators
    localparam logic [1:0] SPF_SETTLE_CYCLES = 2'h3;
    // Ring-oscillator cycles of the detection window
    localparam logic [1:0] SPF_PROBE_TICKS = 2'h2;
    // Ring-oscillator cycles of the confirm window
    localparam logic [1:0] SPF_CONFIRM_TICKS = 2'h1;
    // Interval select codes
    localparam logic [1:0] SPF_IVL_CONT = 2'h0;
    localparam logic [1:0] SPF_IVL_2P11 = 2'h1;
    localparam logic [1:0] SPF_IVL_2P12 = 2'h2;
    localparam logic [1:0] SPF_IVL_2P13 = 2'h3;
    // Interval lengths in ring ticks
    localparam logic [13:0] SPF_TICKS_2P11 = 14'h0800;
    localparam logic [13:0] SPF_TICKS_2P12 = 14'h1000;
    localparam logic [13:0] SPF_TICKS_2P13 = 14'h2000;
    // Reset values
    localparam logic SPF_MONITOR_OFF_RST = 1'b1;
    localparam logic [7:0] SPF_PORT_FOUR_READ_RST = 8'h00;
    // Vector selections
    localparam logic SPF_VEC_WAKE = 1'b0;
    localparam logic SPF_VEC_PFAIL = 1'b1;
    // Sequencer states
    typedef enum logic [8:0] {
        SPF_RUN = 9'h001,
        SPF_STOP = 9'h002,
        SPF_WAKE_CHECK = 9'h004,
        SPF_WARMUP = 9'h008,
        SPF_VECTOR = 9'h010,
        SPF_PF_WAIT = 9'h020,
        SPF_PROBE = 9'h040,
        SPF_CONFIRM = 9'h080,
        SPF_POR_HOLD = 9'h100
    } spf_state_type;
endpackage : spf_pkg

//--- verilog/spf_warmup_timer.sv
// Crystal warm-up counter giving a crystal-ready level
`timescale 1ns/100ps
`default_nettype none
module spf_warmup_timer
    import spf_pkg::*;
#(
    parameter int WARMUP_CYCLES = SPF_WARMUP_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic xtalOn,
    output logic xtalReady
);
    // Refuse a count the counter cannot hold
    if (WARMUP_CYCLES < 1 || WARMUP_CYCLES > 65535)
    begin : gRange
        $error("spf_warmup_timer: WARMUP_CYCLES out of range");
    end

    localparam logic [15:0] LAST = 16'(WARMUP_CYCLES - 1);

    logic [15:0] count_ff; // Cycles since the crystal was enabled
    logic [15:0] nxt_count;
    logic ready_ff; // Warm-up complete
    logic nxt_ready;

    assign xtalReady = ready_ff;

    // Count while the crystal runs, clear when it stops
    always_comb
    begin
        nxt_count = count_ff;
        nxt_ready = ready_ff;
        if (!xtalOn)
        begin
            nxt_count = 16'h0000;
            nxt_ready = 1'b0;
        end
        else if (count_ff == LAST)
            nxt_ready = 1'b1;
        else
            nxt_count = count_ff + 16'h0001;
    end

    // Register counter state
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            count_ff <= 16'h0000;
            ready_ff <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            ready_ff <= nxt_ready;
        end
    end
endmodule : spf_warmup_timer
`default_nettype wire

//--- test/spf_sequencer_props.sv
// Port checks for the stop mode power-fail sequencer
`timescale 1ns/100ps
`default_nettype none
module spf_sequencer_props
    import spf_pkg::*;
#(
    parameter int WARMUP_CYCLES = SPF_WARMUP_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wakeIrq,
    input wire logic abovePowerOnPin,
    input wire logic monitorEn,
    input wire logic regulatorEn,
    input wire logic xtalEn,
    input wire logic sramRetain,
    input wire logic cpuClkEn,
    input wire logic cpuRst,
    input wire logic powerFailWarningFlag,
    input wire logic stopMonitorOff,
    input wire logic vectorValid,
    input wire logic vectorSel,
    input wire logic [7:0] portFourReadData
);
    logic [15:0] waitCnt_ff; // Cycles with crystal on and CPU clock gated
    logic [15:0] nxt_waitCnt;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // Count the warm-up
    always_comb
    begin
        nxt_waitCnt = waitCnt_ff;
        if (!xtalEn || cpuClkEn)
            nxt_waitCnt = 16'h0000;
        else if (waitCnt_ff != 16'hFFFF)
            nxt_waitCnt = waitCnt_ff + 16'h0001;
    end
    // Register the warm-up count
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            waitCnt_ff <= 16'h0000;
        else
            waitCnt_ff <= nxt_waitCnt;
    end
    // Stopped with the monitor off
    sequence sStopped;
        !cpuClkEn && !cpuRst && !regulatorEn && !monitorEn;
    endsequence
    a_stop_gates: assert property ($fell(cpuClkEn) && !cpuRst |-> !regulatorEn && !xtalEn
        && sramRetain && (monitorEn == !stopMonitorOff)) else $error("stop entry gating wrong");
    a_quiet_stop: assert property (sStopped ##0 !wakeIrq |=>
        !cpuRst && !$rose(powerFailWarningFlag)) else $error("reaction while monitor off");
    a_wake_monitor: assert property (sStopped ##0 wakeIrq |-> ##[1:3] monitorEn)
        else $error("monitor not enabled on wake");
    a_warm_early: assert property ($rose(cpuClkEn) |->
        int'(waitCnt_ff) >= WARMUP_CYCLES - 1) else $error("clock before warm-up");
    a_warm_bounded: assert property (int'(waitCnt_ff) <= WARMUP_CYCLES + 24)
        else $error("warm-up never ends");
    a_vector_pulse: assert property (vectorValid |-> cpuClkEn ##1 !vectorValid)
        else $error("vector pulse wrong");
    a_vector_sel: assert property (vectorValid && vectorSel |-> powerFailWarningFlag)
        else $error("power-fail vector without flag");
    a_por_hold: assert property (!abovePowerOnPin [*6] |-> cpuRst && !monitorEn
        && !regulatorEn && !xtalEn) else $error("not held below power-on");
    a_port_four: assert property (portFourReadData == 8'h00)
        else $error("port four read not zero");
    a_monitor_bit: assert property ($fell(rst) |-> stopMonitorOff)
        else $error("monitor off bit reset value");
endmodule : spf_sequencer_props
bind spf_sequencer spf_sequencer_props #(.WARMUP_CYCLES(WARMUP_CYCLES)) uProps (
    .clk_sys, .rst, .wakeIrq, .abovePowerOnPin, .monitorEn, .regulatorEn, .xtalEn,
    .sramRetain, .cpuClkEn, .cpuRst, .powerFailWarningFlag, .stopMonitorOff,
    .vectorValid, .vectorSel, .portFourReadData
);
`default_nettype wire

//--- test/spf_supply_model.sv
// Supply comparators and ring oscillator facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module spf_supply_model
#(
    parameter int POR_MV = 1000,
    parameter int RST_MV = 1700,
    parameter int WARN_MV = 2000
)
(
    input wire logic clk_sys,
    input var int vddMv,
    input wire logic monitorEn,
    output logic aboveWarnPin,
    output logic aboveResetPin,
    output logic abovePowerOnPin,
    output logic ringClkPin
);
    logic noise_ff = 1'b0; // Meaningless level of an unpowered comparator
    logic [1:0] ringDiv_ff = 2'h0; // Ring oscillator divider, period four cycles
    // Free running ring clock and a changing level for dead comparators
    always_ff @(posedge clk_sys)
    begin
        noise_ff <= ~noise_ff;
        ringDiv_ff <= ringDiv_ff + 2'h1;
    end
    // The power-on detector is always alive
    assign abovePowerOnPin = (vddMv > POR_MV);
    // Warning and reset comparators tell nothing while unpowered
    assign aboveWarnPin = monitorEn ? (vddMv > WARN_MV) : noise_ff;
    assign aboveResetPin = monitorEn ? (vddMv > RST_MV) : ~noise_ff;
    assign ringClkPin = ringDiv_ff[1];
endmodule : spf_supply_model
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the stop mode power-fail sequencer
`timescale 1ns/100ps
`default_nettype none
module tb
    import spf_pkg::*;
;
    localparam int WARM = 8; // Short crystal warm-up
    localparam int POR_MV = 1000; // Model thresholds in millivolts
    localparam int RST_MV = 1700;
    localparam int WARN_MV = 2000;
    logic clk_sys, rst, stopReq, wakeIrq, pfPriorityHigher, pfFlagClear;
    logic cfgWrite, cfgStopMonitorOff, portFourWrite, portFourRead;
    logic aboveWarnPin, aboveResetPin, abovePowerOnPin, ringClkPin;
    logic monitorEn, regulatorEn, xtalEn, sramRetain, cpuClkEn, cpuRst;
    logic powerFailWarningFlag, stopMonitorOff, vectorValid, vectorSel;
    logic [1:0] intervalSel;
    logic [7:0] portFourWriteData, portFourReadData;
    int vddMv, fails, comparisons, seed, k, b;
    logic expFlag, expSel;
    spf_sequencer #(.WARMUP_CYCLES(WARM)) DUT (
        .clk_sys, .rst, .stopReq, .wakeIrq, .pfPriorityHigher, .pfFlagClear, .cfgWrite,
        .cfgStopMonitorOff, .intervalSel, .aboveWarnPin, .aboveResetPin, .abovePowerOnPin,
        .ringClkPin, .portFourWrite, .portFourRead, .portFourWriteData, .monitorEn,
        .regulatorEn, .xtalEn, .sramRetain, .cpuClkEn, .cpuRst, .powerFailWarningFlag,
        .stopMonitorOff, .vectorValid, .vectorSel, .portFourReadData
    );
    spf_supply_model #(.POR_MV(POR_MV), .RST_MV(RST_MV), .WARN_MV(WARN_MV)) uSupply (
        .clk_sys, .vddMv, .monitorEn, .aboveWarnPin, .aboveResetPin, .abovePowerOnPin,
        .ringClkPin
    );
    // 100 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Supply band: 0 below power-on, 1 reset band, 2 warning band, 3 healthy
    function automatic int band(input int mv);
        return int'(mv > POR_MV) + int'(mv > RST_MV) + int'(mv > WARN_MV);
    endfunction : band
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    // Step to just after the next edge, outputs settled
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick
    // Output chosen for waiting
    function automatic logic pick(input int which);
        case (which)
            0: return cpuRst;
            1: return monitorEn;
            default: return vectorValid;
        endcase
    endfunction : pick
    // Bounded wait for an output level, cycles left in k
    task automatic waitFor(input int which, input logic lvl, input int lim);
        k = 0;
        while (pick(which) !== lvl && k < lim)
        begin
            tick();
            k++;
        end
        if (k >= lim)
            chk("wait limit", k, 0);
    endtask : waitFor
    // One-cycle request: 0 stop, 1 wake, 2 flag clear, 3 config write
    task automatic pulse(input int which);
        @(posedge clk_sys);
        stopReq <= (which == 0);
        wakeIrq <= (which == 1);
        pfFlagClear <= (which == 2);
        cfgWrite <= (which == 3);
        portFourWriteData <= 8'($random(seed));
        {portFourWrite, portFourRead} <= 2'($random(seed));
        @(posedge clk_sys);
        {stopReq, wakeIrq, pfFlagClear, cfgWrite} <= 4'h0;
        tick();
        chk("port four read", portFourReadData, 8'h00);
    endtask : pulse
    // Verdict and end of run
    task automatic report_and_stop();
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    // Main sequence
    initial
    begin
        {rst, stopReq, wakeIrq, pfPriorityHigher, pfFlagClear, cfgWrite} = 6'h20;
        {portFourWrite, portFourRead, portFourWriteData} = 10'h000;
        cfgStopMonitorOff = 1'b1;
        intervalSel = SPF_IVL_CONT;
        vddMv = 3000;
        seed = 34593;
        fails = 0;
        comparisons = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        tick();
        chk("monitor off bit", stopMonitorOff, 1'b1);
        chk("held in reset", cpuRst, 1'b1);
        waitFor(0, 1'b0, 400);
        chk("clock after warm-up", cpuClkEn, 1'b1);
        // Wakes: warning with each priority, healthy, reset band
        for (int i = 0; i < 4; i++)
        begin
            pulse(0);
            tick();
            chk("stop regulator", regulatorEn, 1'b0);
            chk("stop crystal", xtalEn, 1'b0);
            chk("stop monitor", monitorEn, 1'b0);
            chk("stop retention", sramRetain, 1'b1);
            chk("stop clock", cpuClkEn, 1'b0);
            vddMv = 1500;
            repeat (40) tick();
            chk("quiet reset", cpuRst, 1'b0);
            chk("quiet flag", powerFailWarningFlag, 1'b0);
            vddMv = (i == 3) ? 1500 : (i == 2) ? 3000 : 1800;
            b = band(vddMv);
            expFlag = (b == 2);
            expSel = expFlag && (i == 0);
            @(posedge clk_sys);
            pfPriorityHigher <= (i == 0) || (i > 1 && 1'($random(seed)));
            intervalSel <= (i == 3) ? SPF_IVL_2P11 : SPF_IVL_CONT;
            pulse(1);
            if (b == 1)
            begin
                waitFor(0, 1'b1, 40);
                chk("wake into reset", cpuRst, 1'b1);
                chk("reset band regulator", regulatorEn, 1'b0);
            end
            else
            begin
                waitFor(2, 1'b1, WARM + 60);
                chk("vector choice", vectorSel, expSel);
                chk("warning flag", powerFailWarningFlag, expFlag);
                chk("crystal on", xtalEn & regulatorEn, 1'b1);
                chk("running", cpuRst, 1'b0);
                vddMv = 3000;
                repeat (4) tick();
                pulse(2);
                chk("flag cleared", powerFailWarningFlag, 1'b0);
            end
        end
        // Periodic intervals, then continuous
        for (int s = 1; s < 4; s++)
        begin
            waitFor(1, 1'b0, 200);
            waitFor(1, 1'b1, 40000);
            chk("interval", (k > (4 << (10 + s)) - 16) && (k < (4 << (10 + s)) + 16), 1);
            @(posedge clk_sys);
            intervalSel <= 2'((s + 1) % 4);
        end
        repeat (20) tick();
        b = 0;
        repeat (80)
        begin
            tick();
            b += int'(monitorEn !== 1'b1);
        end
        chk("continuous", b, 0);
        vddMv = 3000;
        repeat (4) tick();
        vddMv = 1500;
        repeat (40) tick();
        chk("short recovery", cpuRst, 1'b1);
        vddMv = 3000;
        waitFor(0, 1'b0, 300);
        chk("release delay", k >= WARM + 8, 1'b1);
        chk("released clock", cpuClkEn, 1'b1);
        // Below power-on
        vddMv = 500;
        repeat (8) tick();
        chk("por hold", {cpuRst, monitorEn, regulatorEn, xtalEn}, 4'h8);
        vddMv = 3000;
        waitFor(0, 1'b0, 400);
        // Monitor kept on in stop
        @(posedge clk_sys);
        cfgStopMonitorOff <= 1'b0;
        pulse(3);
        chk("monitor bit written", stopMonitorOff, 1'b0);
        pulse(0);
        tick();
        chk("stop monitor kept", {monitorEn, regulatorEn}, 2'h2);
        pulse(1);
        waitFor(2, 1'b1, WARM + 60);
        chk("healthy vector", vectorSel, 1'b0);
        report_and_stop();
    end
    // Hang guard
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        fails++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
